//--- design/dc_sdram_control.sv
// module: display cache sdram timing registers and special command mode steering
// How it works
// RULE_01: paging bit 0 keeps pages open, 1 closes pages after access.
// RULE_02: override bit 0 follows latency; 1 fixes activate-to-access delay at 2.
// RULE_03: latency bit 0 gives latency and delay 2; 1 gives 3 (reset).
// RULE_04: row timing bit selects active-to-precharge of 5 or 7 clocks.
// RULE_05: row timing bit selects refresh-to-activate of 8 or 10 clocks.
// RULE_06: precharge bit selects precharge time of 2 or 3 clocks.
// RULE_07: refresh field 00 stops refresh, 01 runs it; 10, 11 reserved.
// RULE_08: software halts refresh only briefly and restores it promptly.
// RULE_09: special mode 000 performs ordinary reads and writes.
// RULE_10: special mode 001 turns every memory cycle into a nop.
// RULE_11: special mode 010 turns every memory cycle into precharge-all.
// RULE_12: special mode 011 turns every memory cycle into mode register set.
// RULE_13: mode set carries burst length, wrap and latency from host address.
// RULE_14: mode set forces memory address bits 11 to 7 to zero.
// RULE_15: special mode 100 issues cbr refresh; 101 and 11x reserved.
// RULE_16: software selects nop mode before any other special mode.
// RULE_17: software picks host addresses yielding the wanted mode value.
// RULE_18: reserved bits 7:5 of both registers read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none

module dc_sdram_control
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [15:0]            reg_addr,
	input  wire logic [7:0]             reg_wdata,
	output logic      [7:0]             reg_rdata,
	input  wire logic                   cycle_valid,
	input  wire logic [11:0]            cycle_addr,
	output dc_sdram_pkg::mem_cmd_t      mem_cmd,
	output logic      [11:0]            memory_address_lines,
	output dc_sdram_pkg::timing_t       timing,
	output logic                        refresh_enable,
	output logic                        special_active
);

	// ********************************************
	// register selects
	// ********************************************
	logic sel_timing_low;
	logic sel_refresh_mode;
	logic wr_timing_low;
	logic wr_refresh_mode;

	// full compare: neighbouring offsets stay unmapped and read as zero
	assign sel_timing_low   = (reg_addr == dc_sdram_pkg::timing_low_offset);
	assign sel_refresh_mode = (reg_addr == dc_sdram_pkg::refresh_mode_offset);
	assign wr_timing_low    = reg_wr && sel_timing_low;
	assign wr_refresh_mode  = reg_wr && sel_refresh_mode;

	// ********************************************
	// control registers
	// ********************************************
	logic [7:0] timing_low_q;
	logic [7:0] timing_low_d;
	logic [7:0] refresh_mode_q;
	logic [7:0] refresh_mode_d;

	always_comb
	begin
		timing_low_d   = timing_low_q;
		refresh_mode_d = refresh_mode_q;
		if (wr_timing_low)
		begin
			// reserved bits are never stored, so they read back as zero
			timing_low_d = reg_wdata & dc_sdram_pkg::writable_mask; // [RULE_18]
		end
		if (wr_refresh_mode)
		begin
			refresh_mode_d = reg_wdata & dc_sdram_pkg::writable_mask; // [RULE_18]
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			timing_low_q   <= dc_sdram_pkg::timing_low_reset;
			refresh_mode_q <= dc_sdram_pkg::refresh_mode_reset;
		end
		else
		begin
			timing_low_q   <= timing_low_d;
			refresh_mode_q <= refresh_mode_d;
		end
	end

	// ********************************************
	// read back
	// ********************************************
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// registered, so a read in the cycle of a write still returns the old value
	always_comb
	begin
		rdata_d = rdata_q;
		if (reg_rd)
		begin
			if (sel_timing_low)
			begin
				rdata_d = timing_low_q;
			end
			else if (sel_refresh_mode)
			begin
				rdata_d = refresh_mode_q;
			end
			else
			begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ********************************************
	// timing decode
	// ********************************************
	timing_decode i_timing_decode
	(
		.ctrl   (timing_low_q),
		.timing (timing)
	);

	// ********************************************
	// refresh and special mode
	// ********************************************
	logic [1:0] refresh_rate;
	logic [2:0] special_mode_field;
	logic       refresh_on;

	assign refresh_rate       = refresh_mode_q[dc_sdram_pkg::refresh_rate_lsb +: 2];
	assign special_mode_field = refresh_mode_q[dc_sdram_pkg::special_mode_lsb +: 3];

	// reserved rate codes keep refresh off rather than guess at a rate
	always_comb
	begin
		case (refresh_rate)
			dc_sdram_pkg::refresh_off:
			begin
				refresh_on = 1'b0; // [RULE_07]
			end
			dc_sdram_pkg::refresh_normal:
			begin
				refresh_on = 1'b1; // [RULE_07]
			end
			default:
			begin
				refresh_on = 1'b0;
			end
		endcase
	end

	assign refresh_enable = refresh_on;
	assign special_active = (special_mode_field != dc_sdram_pkg::mode_normal);

	dc_sdram_pkg::mem_cmd_t cmd_q;
	dc_sdram_pkg::mem_cmd_t cmd_d;

	always_comb
	begin
		cmd_d.valid = cycle_valid;
		cmd_d.addr  = cycle_addr;
		case (special_mode_field)
			dc_sdram_pkg::mode_normal:
			begin
				cmd_d.cmd = dc_sdram_pkg::cmd_access; // [RULE_09]
			end
			dc_sdram_pkg::noop_command_mode:
			begin
				cmd_d.cmd = dc_sdram_pkg::cmd_nop; // [RULE_10]
			end
			dc_sdram_pkg::precharge_all_mode:
			begin
				cmd_d.cmd = dc_sdram_pkg::cmd_precharge; // [RULE_11]
			end
			dc_sdram_pkg::mode_register_set_mode:
			begin
				cmd_d.cmd  = dc_sdram_pkg::cmd_mrs; // [RULE_12]
				// burst, wrap and latency pass from host address bits 6:0
				cmd_d.addr = {dc_sdram_pkg::mrs_zero_bits, cycle_addr[6:0]}; // [RULE_13] [RULE_14]
			end
			dc_sdram_pkg::cbr_refresh_mode:
			begin
				cmd_d.cmd = dc_sdram_pkg::cmd_refresh; // [RULE_15]
			end
			default:
			begin
				// reserved codes: safest to issue nothing harmful
				cmd_d.cmd = dc_sdram_pkg::cmd_nop;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmd_q <= '{valid: 1'b0, cmd: dc_sdram_pkg::cmd_nop, addr: 12'h000};
		end
		else
		begin
			cmd_q <= cmd_d;
		end
	end

	assign mem_cmd              = cmd_q;
	assign memory_address_lines = cmd_q.addr;

endmodule : dc_sdram_control
`default_nettype wire

//--- design/dc_sdram_pkg.sv
// package: register map, field layout, commands and timing for the display cache sdram control
package dc_sdram_pkg;

	// ********************************************
	// register map
	// ********************************************
	localparam logic [15:0] timing_low_offset  = 16'h3001;
	localparam logic [15:0] refresh_mode_offset = 16'h3002;
	localparam logic [7:0]  timing_low_reset   = 8'h17;
	localparam logic [7:0]  refresh_mode_reset = 8'h08;
	localparam logic [7:0]  writable_mask      = 8'h1f;

	// ********************************************
	// field positions
	// ********************************************
	localparam int paging_policy_bit          = 4;
	localparam int row_to_column_override_bit = 3;
	localparam int column_latency_bit         = 2;
	localparam int row_timing_bit             = 1;
	localparam int precharge_timing_bit       = 0;
	localparam int refresh_rate_lsb           = 3;
	localparam int special_mode_lsb           = 0;

	localparam logic [1:0] refresh_off    = 2'h0;
	localparam logic [1:0] refresh_normal = 2'h1;

	localparam logic [2:0] mode_normal       = 3'h0;
	localparam logic [2:0] noop_command_mode = 3'h1;
	localparam logic [2:0] precharge_all_mode = 3'h2;
	localparam logic [2:0] mode_register_set_mode = 3'h3;
	localparam logic [2:0] cbr_refresh_mode  = 3'h4;

	// ********************************************
	// timing counts in local memory clocks, then the mode set zero address bits
	// ********************************************
	localparam logic [3:0] rcd_fixed      = 4'h2;
	localparam logic [3:0] cl_short       = 4'h2;
	localparam logic [3:0] cl_long        = 4'h3;
	localparam logic [3:0] ras_short      = 4'h5;
	localparam logic [3:0] ras_long       = 4'h7;
	localparam logic [3:0] rc_short       = 4'h8;
	localparam logic [3:0] rc_long        = 4'ha;
	localparam logic [3:0] rp_short       = 4'h2;
	localparam logic [3:0] rp_long        = 4'h3;
	localparam logic [4:0] mrs_zero_bits  = 5'h00;

	// ********************************************
	// carried groups
	// ********************************************
	typedef struct packed
	{
		logic       close_pages;
		logic [3:0] rcd;
		logic [3:0] cas_latency;
		logic [3:0] ras_min;
		logic [3:0] rc_min;
		logic [3:0] rp;
	} timing_t;

	typedef enum logic [4:0]
	{
		cmd_access    = 5'b00001,
		cmd_nop       = 5'b00010,
		cmd_precharge = 5'b00100,
		cmd_mrs       = 5'b01000,
		cmd_refresh   = 5'b10000
	} cmd_t;

	typedef struct packed
	{
		logic        valid;
		cmd_t        cmd;
		logic [11:0] addr;
	} mem_cmd_t;

endpackage : dc_sdram_pkg

//--- design/timing_decode.sv
// module: decodes the timing control byte into cycle counts
`timescale 1ns/1ps
`default_nettype none

module timing_decode
(
	input  wire logic [7:0]           ctrl,
	output dc_sdram_pkg::timing_t     timing
);

	always_comb
	begin
		timing.close_pages = ctrl[dc_sdram_pkg::paging_policy_bit]; // [RULE_01]
		timing.cas_latency = ctrl[dc_sdram_pkg::column_latency_bit] ?
			dc_sdram_pkg::cl_long : dc_sdram_pkg::cl_short; // [RULE_03]
		timing.rcd = ctrl[dc_sdram_pkg::row_to_column_override_bit] ?
			dc_sdram_pkg::rcd_fixed : timing.cas_latency; // [RULE_02]
		timing.ras_min = ctrl[dc_sdram_pkg::row_timing_bit] ?
			dc_sdram_pkg::ras_long : dc_sdram_pkg::ras_short; // [RULE_04]
		timing.rc_min = ctrl[dc_sdram_pkg::row_timing_bit] ?
			dc_sdram_pkg::rc_long : dc_sdram_pkg::rc_short; // [RULE_05]
		timing.rp = ctrl[dc_sdram_pkg::precharge_timing_bit] ?
			dc_sdram_pkg::rp_long : dc_sdram_pkg::rp_short; // [RULE_06]
	end

endmodule : timing_decode
`default_nettype wire

//--- sim/sdram_model.sv
// sdram device model: latches mode register and counts refreshes
`timescale 1ns/1ps
`default_nettype none
module sdram_model
(
	input  wire clk,
	input  wire dc_sdram_pkg::mem_cmd_t mem_cmd,
	output logic [11:0] mode_reg,
	output int refresh_count
);
	logic [11:0] mode_q = 12'h000;
	int refreshes = 0;
	always @(posedge clk)
		if (mem_cmd.valid && mem_cmd.cmd == dc_sdram_pkg::cmd_mrs)
			mode_q <= mem_cmd.addr;
		else if (mem_cmd.valid && mem_cmd.cmd == dc_sdram_pkg::cmd_refresh)
			refreshes <= refreshes + 1;
	assign mode_reg = mode_q;
	assign refresh_count = refreshes;
endmodule : sdram_model
`default_nettype wire

//--- sim/dc_sdram_control_sva.sv
// checker: timing decode and command steering relations
`timescale 1ns/1ps
`default_nettype none
module dc_sdram_control_sva
(
	input wire clk,
	input wire rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire cycle_valid,
	input wire [11:0] cycle_addr,
	input wire dc_sdram_pkg::mem_cmd_t mem_cmd,
	input wire [11:0] memory_address_lines,
	input wire dc_sdram_pkg::timing_t timing,
	input wire refresh_enable,
	input wire special_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_mv; mem_cmd.valid == $past(cycle_valid); endproperty
	a_mv: assert property (p_mv) else $error("cmd valid lag");
	property p_acc; cycle_valid && !special_active |=> mem_cmd.cmd == dc_sdram_pkg::cmd_access
		&& memory_address_lines == $past(cycle_addr); endproperty
	a_acc: assert property (p_acc) else $error("normal access");
	property p_sp; cycle_valid && special_active |=> mem_cmd.cmd != dc_sdram_pkg::cmd_access; endproperty
	a_sp: assert property (p_sp) else $error("special cmd");
	property p_mrs; mem_cmd.valid && mem_cmd.cmd == dc_sdram_pkg::cmd_mrs |->
		memory_address_lines == {5'h00, $past(cycle_addr[6:0])}; endproperty
	a_mrs: assert property (p_mrs) else $error("mode set addr");
	property p_rcd; reg_wr && reg_addr == 16'h3001 |=> timing.cas_latency == ($past(reg_wdata[2]) ? 4'h3 : 4'h2)
		&& timing.rcd == (($past(reg_wdata[3]) || !$past(reg_wdata[2])) ? 4'h2 : 4'h3); endproperty
	a_rcd: assert property (p_rcd) else $error("rcd or latency");
	property p_ras; reg_wr && reg_addr == 16'h3001 |=> timing.ras_min == ($past(reg_wdata[1]) ? 4'h7 : 4'h5)
		&& timing.rc_min == ($past(reg_wdata[1]) ? 4'ha : 4'h8); endproperty
	a_ras: assert property (p_ras) else $error("ras rc pair");
	property p_lo; reg_wr && reg_addr == 16'h3001 |=> timing.rp == ($past(reg_wdata[0]) ? 4'h3 : 4'h2)
		&& timing.close_pages == $past(reg_wdata[4]); endproperty
	a_lo: assert property (p_lo) else $error("precharge or paging");
	property p_ref; reg_wr && reg_addr == 16'h3002 |=> refresh_enable == ($past(reg_wdata[4:3]) == 2'h1); endproperty
	a_ref: assert property (p_ref) else $error("refresh enable");
	property p_rsv; reg_rd |=> reg_rdata[7:5] == 3'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits");
	c_sp: cover property (cycle_valid && special_active);
	c_mrs: cover property (mem_cmd.valid && mem_cmd.cmd == dc_sdram_pkg::cmd_mrs);
	c_wr: cover property (reg_wr && reg_addr == 16'h3002);
endmodule : dc_sdram_control_sva
bind dc_sdram_control dc_sdram_control_sva i_dc_sdram_control_sva (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata, .cycle_valid, .cycle_addr, .mem_cmd, .memory_address_lines, .timing,
	.refresh_enable, .special_active);
`default_nettype wire

//--- sim/dc_sdram_control_bench.sv
// bench: registers, timing decode and special commands
`timescale 1ns/1ps
`default_nettype none
module dc_sdram_control_bench;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cycle_valid = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
	logic [11:0] cycle_addr = 12'h000, memory_address_lines, mode_seen, a;
	dc_sdram_pkg::mem_cmd_t mem_cmd;
	dc_sdram_pkg::timing_t timing;
	logic refresh_enable, special_active;
	int err_total = 0, samples_checked = 0, seed = 26635, cycles = 0, cbr_seen;
	always #20 clk = ~clk;
	dc_sdram_control i_dc_sdram_control (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.cycle_valid, .cycle_addr, .mem_cmd, .memory_address_lines, .timing, .refresh_enable, .special_active);
	sdram_model i_sdram_model (.clk, .mem_cmd, .mode_reg(mode_seen), .refresh_count(cbr_seen));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// one idle edge before each strobe so no signal is set twice in a step
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		@(posedge clk) #1;
		reg_addr = ad;
		reg_rd = 1'b1;
		@(posedge clk) #1;
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask : rd
	function automatic dc_sdram_pkg::timing_t exp_t(input logic [7:0] x);
		logic [3:0] cl;
		cl = x[2] ? 4'h3 : 4'h2;
		return {x[4], x[3] ? 4'h2 : cl, cl, x[1] ? 4'h7 : 4'h5, x[1] ? 4'ha : 4'h8, x[0] ? 4'h3 : 4'h2};
	endfunction : exp_t
	function automatic logic [17:0] exp_c(input logic [2:0] m, input logic [11:0] ad);
		case (m)
			3'h0: return {1'b1, 5'h01, ad};
			3'h2: return {1'b1, 5'h04, ad};
			3'h3: return {1'b1, 5'h08, 5'h00, ad[6:0]};
			3'h4: return {1'b1, 5'h10, ad};
			default: return {1'b1, 5'h02, ad};
		endcase
	endfunction : exp_c
	task automatic cyc(input logic [2:0] m, input logic [11:0] ad);
		@(posedge clk) #1;
		cycle_addr = ad;
		cycle_valid = 1'b1;
		@(posedge clk) #1;
		cycle_valid = 1'b0;
		chk(mem_cmd, exp_c(m, ad));
		chk(memory_address_lines, 12'(exp_c(m, ad)));
	endtask : cyc
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			stop_test();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		rd(16'h3001, 8'h17);
		rd(16'h3002, 8'h08);
		chk(timing, exp_t(8'h17));
		chk(refresh_enable, 1'b1);
		$display("reset test done");
		for (int i = 0; i < 40; i++)
		begin
			v = (i < 32) ? (i[7:0] | 8'he0) : 8'($random(seed));
			wr(16'h3001, v);
			chk(timing, exp_t(v));
			rd(16'h3001, v & 8'h1f);
		end
		$display("timing test done");
		for (int r = 0; r < 4; r++)
		begin
			wr(16'h3002, {3'h7, r[1:0], 3'h0});
			chk(refresh_enable, r == 1);
		end
		// halt kept short, normal refresh back at once
		wr(16'h3002, 8'h08);
		$display("refresh test done");
		// nop mode comes first, normal mode last
		for (int k = 1; k <= 8; k++)
		begin
			wr(16'h3002, {5'h01, k[2:0]});
			chk(special_active, k[2:0] != 3'h0);
			if (k == 4)
				chk(mode_seen, {5'h00, a[6:0]});
			repeat (3)
			begin
				a = 12'($random(seed));
				cyc(k[2:0], a);
			end
		end
		chk(cbr_seen, 3);
		$display("command test done");
		wr(16'h3003, 8'hff);
		rd(16'h3003, 8'h00);
		rd(16'h3000, 8'h00);
		rd(16'h3002, 8'h08);
		$display("unmapped test done");
		// reset in mid-run brings every register back to its default
		wr(16'h3001, 8'h00);
		wr(16'h3002, 8'h01);
		@(posedge clk) #1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk(mem_cmd, 18'h02000);
		chk(timing, exp_t(8'h17));
		chk(refresh_enable, 1'b1);
		chk(special_active, 1'b0);
		rd(16'h3001, 8'h17);
		rd(16'h3002, 8'h08);
		$display("mid-run reset test done");
		stop_test();
	end
endmodule : dc_sdram_control_bench
`default_nettype wire
